// >>> pkg/dgsb_regs.vh
`ifndef DGSB_REGS_VH
`define DGSB_REGS_VH
`define DGSB_GPIO_W 17
`define DGSB_PIN_TEMP 0
`define DGSB_PIN_ALERT 1
`define DGSB_PIN_PWROK 2
`define DGSB_PIN_PEER_IRQ_IN 3
`define DGSB_PIN_STAT_DATA 4
`define DGSB_PIN_STAT_CLK 5
`define DGSB_PIN_PEER_RST 6
`define DGSB_PIN_PEER_IRQ_OUT 7
`define DGSB_PIN_PROG 8
`define DGSB_STAT_W 16
`define DGSB_STAT_INIT_BIT 8
`define DGSB_STAT_DONE_BIT 9
`define DGSB_CLK_MHZ 100
`define DGSB_IDLE_LOW_US 1000
`define DGSB_IDLE_LOW_CYC (`DGSB_IDLE_LOW_US * `DGSB_CLK_MHZ)
`define DGSB_BOOT_NOR_OR_LINK 2'h0
`define DGSB_BOOT_SRIO 2'h1
`define DGSB_BOOT_PCIE 2'h2
`define DGSB_BOOT_NONE 2'h3
`endif

// >>> core/dgsb_sync.v
`timescale 1ns/1ns
`default_nettype none
module dgsb_sync #(
  parameter W = 1
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> core/dgsb_status_shift.v
`timescale 1ns/1ns
`default_nettype none
`include "dgsb_regs.vh"
module dgsb_status_shift #(
  parameter [31:0] IDLE_LOW_CYC = `DGSB_IDLE_LOW_CYC
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire stat_clk_s,
  input wire [`DGSB_STAT_W-1:0] status_word,
  output reg stat_data_q
);
  reg clk_prev_q;
  reg [31:0] low_cnt_q;
  reg [4:0] bit_idx_q;
  wire fall = clk_prev_q & ~stat_clk_s;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_q <= 1'b0;
      low_cnt_q <= 32'h0;
      bit_idx_q <= 5'h0;
      stat_data_q <= 1'b0;
    end else if (clk_en) begin
      clk_prev_q <= stat_clk_s;
      if (stat_clk_s) begin
        low_cnt_q <= 32'h0;
      end else if (low_cnt_q <= IDLE_LOW_CYC) begin
        low_cnt_q <= low_cnt_q + 32'h1;
      end
      // Long low time restarts the word; this outranks the advance.
      if (!stat_clk_s && low_cnt_q >= IDLE_LOW_CYC) begin
        bit_idx_q <= 5'h0;
      end else if (fall && bit_idx_q < `DGSB_STAT_W) begin
        bit_idx_q <= bit_idx_q + 5'h1;
      end
      // Data is stable while the clock is high so the processor may sample it.
      if (bit_idx_q < `DGSB_STAT_W) begin
        stat_data_q <= status_word[bit_idx_q[3:0]];
      end else begin
        stat_data_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/dgsb_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "dgsb_regs.vh"
module dgsb_ctrl #(
  parameter [31:0] IDLE_LOW_CYC = `DGSB_IDLE_LOW_CYC
) (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  input wire [7:0] dip_switch_bits,
  input wire temp_alarm,
  input wire host_alert,
  input wire host_power_ok,
  input wire fpga_init_n,
  input wire fpga_done,
  input wire watchdog_timeout,
  input wire board_reset_a_req,
  input wire board_reset_b_req,
  input wire [`DGSB_GPIO_W-1:0] gpio_a_in,
  input wire [`DGSB_GPIO_W-1:0] gpio_b_in,
  output reg [`DGSB_GPIO_W-1:0] gpio_a_out,
  output reg [`DGSB_GPIO_W-1:0] gpio_a_oe,
  output reg [`DGSB_GPIO_W-1:0] gpio_b_out,
  output reg [`DGSB_GPIO_W-1:0] gpio_b_oe,
  output reg dsp_a_reset_n,
  output reg dsp_b_reset_n,
  output reg fpga_program_n
);
  // Boot pattern per code: the mapping to strap bits is board specific, kept as a table.
  function [`DGSB_GPIO_W-1:0] boot_pattern;
    input is_b;
    input [1:0] code;
    begin
      case (code)
        `DGSB_BOOT_NOR_OR_LINK: boot_pattern = is_b ? 17'h00010 : 17'h00001;
        `DGSB_BOOT_SRIO: boot_pattern = 17'h00002;
        `DGSB_BOOT_PCIE: boot_pattern = 17'h00004;
        default: boot_pattern = 17'h00000;
      endcase
    end
  endfunction

  wire [7:0] sw_s;
  wire [4:0] misc_s;
  wire [3:0] a_s;
  wire [3:0] b_s;
  dgsb_sync #(.W(8)) u_sync_sw (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .async_in(dip_switch_bits), .sync_out(sw_s)
  );
  dgsb_sync #(.W(5)) u_sync_misc (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .async_in({temp_alarm, host_alert, host_power_ok, watchdog_timeout, fpga_done}),
    .sync_out(misc_s)
  );
  dgsb_sync #(.W(4)) u_sync_a (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .async_in({gpio_a_in[`DGSB_PIN_STAT_CLK], gpio_a_in[`DGSB_PIN_PEER_RST],
               gpio_a_in[`DGSB_PIN_PEER_IRQ_OUT], gpio_a_in[`DGSB_PIN_PROG]}),
    .sync_out(a_s)
  );
  dgsb_sync #(.W(4)) u_sync_b (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .async_in({gpio_b_in[`DGSB_PIN_STAT_CLK], gpio_b_in[`DGSB_PIN_PEER_RST],
               gpio_b_in[`DGSB_PIN_PEER_IRQ_OUT], gpio_b_in[`DGSB_PIN_PROG]}),
    .sync_out(b_s)
  );
  wire init_s;
  dgsb_sync #(.W(1)) u_sync_init (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .async_in(fpga_init_n), .sync_out(init_s)
  );

  // Switch 1 is bit 0; ON is already high at the pin.
  wire [`DGSB_STAT_W-1:0] status_word = {6'h00, misc_s[0], init_s, sw_s};
  wire stat_a;
  wire stat_b;
  dgsb_status_shift #(.IDLE_LOW_CYC(IDLE_LOW_CYC)) u_stat_a (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .stat_clk_s(a_s[3]), .status_word(status_word), .stat_data_q(stat_a)
  );
  dgsb_status_shift #(.IDLE_LOW_CYC(IDLE_LOW_CYC)) u_stat_b (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .stat_clk_s(b_s[3]), .status_word(status_word), .stat_data_q(stat_b)
  );

  // A processor's own reset request pin is ignored while that processor is held in reset.
  wire rst_a_d = board_reset_a_req | misc_s[1] | (dsp_b_reset_n & b_s[2]);
  wire rst_b_d = board_reset_b_req | misc_s[1] | (dsp_a_reset_n & a_s[2]);

  wire [`DGSB_GPIO_W-1:0] run_mask = 17'h000FF; // Pins 9-16 left to the gate array.
  wire [`DGSB_GPIO_W-1:0] run_oe_a = 17'h0001F & run_mask;
  wire [`DGSB_GPIO_W-1:0] run_oe_b = 17'h0001F & run_mask;
  // Pin 8 is passed on only once the synchroniser holds levels sampled after release.
  // Until then it shows its reset zero or the boot pattern, and a stale low would restart the gate array.
  reg [1:0] a_live_q;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dsp_a_reset_n <= 1'b0;
      dsp_b_reset_n <= 1'b0;
      gpio_a_out <= 17'h00000;
      gpio_a_oe <= 17'h1FFFF;
      gpio_b_out <= 17'h00000;
      gpio_b_oe <= 17'h1FFFF;
      fpga_program_n <= 1'b1;
      a_live_q <= 2'h0;
    end else if (clk_en) begin
      dsp_a_reset_n <= ~rst_a_d;
      dsp_b_reset_n <= ~rst_b_d;
      if (rst_a_d) begin
        a_live_q <= 2'h0;
      end else if (a_live_q != 2'h3) begin
        a_live_q <= a_live_q + 2'h1;
      end
      if (rst_a_d) begin
        gpio_a_out <= boot_pattern(1'b0, sw_s[1:0]);
        gpio_a_oe <= 17'h1FFFF;
        fpga_program_n <= 1'b1;
      end else begin
        // Same pin map on both sides.
        gpio_a_out <= {14'h0000, misc_s[2], misc_s[3], misc_s[4]} |
                      ({16'h0000, b_s[1]} << `DGSB_PIN_PEER_IRQ_IN) |
                      ({16'h0000, stat_a} << `DGSB_PIN_STAT_DATA);
        gpio_a_oe <= run_oe_a;
        fpga_program_n <= (a_live_q == 2'h3) ? a_s[0] : 1'b1;
      end
      if (rst_b_d) begin
        gpio_b_out <= boot_pattern(1'b1, sw_s[5:4]);
        gpio_b_oe <= 17'h1FFFF;
      end else begin
        // Pin 8 of the second processor is not looked at.
        gpio_b_out <= {14'h0000, misc_s[2], misc_s[3], misc_s[4]} |
                      ({16'h0000, a_s[1]} << `DGSB_PIN_PEER_IRQ_IN) |
                      ({16'h0000, stat_b} << `DGSB_PIN_STAT_DATA);
        gpio_b_oe <= run_oe_b;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dgsb_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dgsb_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic temp_alarm,
  input wire logic watchdog_timeout,
  input wire logic [16:0] gpio_a_in,
  input wire logic [16:0] gpio_a_out,
  input wire logic [16:0] gpio_a_oe,
  input wire logic [16:0] gpio_b_out,
  input wire logic [16:0] gpio_b_oe,
  input wire logic dsp_a_reset_n,
  input wire logic dsp_b_reset_n,
  input wire logic fpga_program_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Five cycles cover two sync flops plus the output register with margin.
  temp_fwd_a: assert property ((dsp_a_reset_n && temp_alarm)[*5] |-> gpio_a_out[0])
    else $error("temp alarm not forwarded");
  temp_idle_a: assert property ((dsp_b_reset_n && !temp_alarm)[*5] |-> !gpio_b_out[0])
    else $error("temp alarm stuck on peer");
  peer_irq_a: assert property ((dsp_b_reset_n && gpio_a_in[7])[*5] |-> gpio_b_out[3])
    else $error("peer interrupt lost");
  peer_rst_a: assert property ((dsp_a_reset_n && gpio_a_in[6])[*5] |-> !dsp_b_reset_n)
    else $error("peer reset ignored");
  wdog_rst_a: assert property (watchdog_timeout[*4] |-> !(dsp_a_reset_n || dsp_b_reset_n))
    else $error("watchdog did not reset both");
  prog_pass_a: assert property ((dsp_a_reset_n && !gpio_a_in[8])[*5] |-> !fpga_program_n)
    else $error("program control not passed");
  run_oe_a: assert property (dsp_a_reset_n |-> gpio_a_oe == 17'h0001F)
    else $error("running pin enables wrong");
  boot_oe_a: assert property (!dsp_b_reset_n |-> gpio_b_oe == 17'h1FFFF)
    else $error("boot pins not all driven");
  cover property (watchdog_timeout ##4 !dsp_a_reset_n);
  cover property (gpio_a_in[6] && !dsp_b_reset_n);
  cover property (dsp_a_reset_n && !fpga_program_n);
endmodule
bind dgsb_ctrl dgsb_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .temp_alarm(temp_alarm),
  .watchdog_timeout(watchdog_timeout), .gpio_a_in(gpio_a_in), .gpio_a_out(gpio_a_out), .gpio_a_oe(gpio_a_oe),
  .gpio_b_out(gpio_b_out), .gpio_b_oe(gpio_b_oe), .dsp_a_reset_n(dsp_a_reset_n),
  .dsp_b_reset_n(dsp_b_reset_n), .fpga_program_n(fpga_program_n));
`default_nettype wire

// >>> testbench/dgsb_dsp_model.sv
`timescale 1ns/1ns
`default_nettype none
module dgsb_dsp_model (
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  input wire logic [2:0] sw_req,
  output logic [16:0] pin_in
);
  logic sclk = 1'b0;
  logic tog = 1'b0;
  always #4 tog = ~tog;
  // Undriven pins toggle, except pin 5 (status clock) and pins 6-8 (sw_req), so that a stale level can never pass for a real one.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & {{8{tog}}, sw_req, sclk, {5{tog}}});
  task automatic read_status(input int idle, output logic [15:0] w);
    sclk = 1'b0;
    // The extra 2 ns keeps every link edge clear of the controller's sampling edge when called on a falling edge.
    #(idle + 2);
    for (int i = 0; i < 16; i++) begin
      sclk = 1'b1;
      #60;
      w[i] = pin_in[4];
      sclk = 1'b0;
      #65;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] dip = 8'h21;
  logic [2:0] irq = 3'h0;
  logic init_n = 1'b1;
  logic done = 1'b0;
  logic wdog = 1'b0;
  logic [2:0] req_a = 3'h4;
  logic [2:0] req_b = 3'h0;
  logic [16:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic rst_a_n, rst_b_n, prog_n;
  logic [15:0] w;
  int error_cnt = 0;
  int n_compared = 0;
  // Row: temp, alert, power-good, A pin7, A pin8, B pin7, B pin8, then A[3:0], B[3:0], program.
  logic [15:0] rows [4] = '{16'h9032, 16'h5A55, 16'h2788, 16'h0801};
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  dgsb_ctrl #(.IDLE_LOW_CYC(32'h32)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .dip_switch_bits(dip), .temp_alarm(irq[2]), .host_alert(irq[1]), .host_power_ok(irq[0]),
    .fpga_init_n(init_n), .fpga_done(done), .watchdog_timeout(wdog), .board_reset_a_req(1'b0),
    .board_reset_b_req(1'b0), .gpio_a_in(a_in), .gpio_b_in(b_in), .gpio_a_out(a_out), .gpio_a_oe(a_oe),
    .gpio_b_out(b_out), .gpio_b_oe(b_oe), .dsp_a_reset_n(rst_a_n), .dsp_b_reset_n(rst_b_n),
    .fpga_program_n(prog_n));
  dgsb_dsp_model pa (.pin_out(a_out), .pin_oe(a_oe), .sw_req(req_a), .pin_in(a_in));
  dgsb_dsp_model pb (.pin_out(b_out), .pin_oe(b_oe), .sw_req(req_b), .pin_in(b_in));
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [16:0] boot(input logic b, input logic [1:0] c);
    boot = (c == 2'h0) ? (b ? 17'h00010 : 17'h00001) : (c == 2'h3) ? 17'h00000 : 17'h00001 << c;
  endfunction
  task automatic settle;
    repeat (6) @(negedge sys_clk);
  endtask
  initial begin
    #50000;
    error_cnt++;
    complete_run();
  end
  initial begin
    settle();
    reset_n = 1'b1;
    settle();
    check({a_oe[16:9], b_oe[16:9], rst_a_n}, 17'h00001);
    foreach (rows[i]) begin
      {irq, req_a[1], req_a[2], req_b[1], req_b[2]} = rows[i][15:9];
      settle();
      check({8'h00, a_out[3:0], b_out[3:0], prog_n}, {8'h00, rows[i][8:0]});
    end
    req_a = 3'h5;
    settle();
    check({15'h0000, rst_a_n, rst_b_n}, 17'h00002);
    req_a = 3'h4;
    wdog = 1'b1;
    for (int c = 0; c < 4; c++) begin
      dip = {2'h0, c[1:0], 2'h0, 2'h3 - c[1:0]};
      settle();
      check(a_out, boot(1'b0, 2'h3 - c[1:0]));
      check(b_out, boot(1'b1, c[1:0]));
    end
    check({15'h0000, rst_a_n, rst_b_n}, 17'h00000);
    wdog = 1'b0;
    dip = 8'hA5;
    settle();
    pa.read_status(1000, w);
    check({1'b0, w}, 17'h001A5);
    @(negedge sys_clk);
    init_n = 1'b0;
    done = 1'b1;
    pb.read_status(1000, w);
    check({1'b0, w}, 17'h002A5);
    @(negedge sys_clk);
    pb.read_status(200, w);
    check({1'b0, w}, 17'h00000);
    @(negedge sys_clk);
    pb.read_status(1000, w);
    check({1'b0, w}, 17'h002A5);
    @(negedge sys_clk);
    reset_n = 1'b0;
    @(negedge sys_clk);
    check(a_oe & b_oe, 17'h1FFFF);
    check({14'h0000, rst_a_n, rst_b_n, prog_n}, 17'h00001);
    reset_n = 1'b1;
    repeat (3) begin
      @(negedge sys_clk);
      check({16'h0000, prog_n}, 17'h00001);
    end
    settle();
    check({15'h0000, rst_a_n, rst_b_n}, 17'h00003);
    complete_run();
  end
endmodule
`default_nettype wire
